//--- src/cwd_cfg.svh
// Constants for the crank wheel decoder and fault monitor
`ifndef CWD_CFG_SVH
`define CWD_CFG_SVH
`define CWD_WHEEL_POS       60
`define CWD_WHEEL_MISSING   2
`define CWD_PULSES_PER_REV  58
`define CWD_CLK_MHZ         200
`define CWD_TIMEOUT_MS      3000
`define CWD_TIMEOUT_CYC     (`CWD_TIMEOUT_MS * 1000 * `CWD_CLK_MHZ)
`define CWD_WARMUP_CLEAR    25
`define CWD_FAULT_SPN       10'h27C
`define CWD_FAULT_FMI       5'h02
`define CWD_PER_W           32
`define CWD_TOOTH_W         6
`define CWD_PERIOD_INIT     32'h0000_0000
`endif

//--- src/cwd_cycle_tracker.sv
// Consecutive ignition and warm-up cycle bookkeeping for the lamp and code
`timescale 1ns/100ps
`default_nettype none
`include "cwd_cfg.svh"
module cwd_cycle_tracker #(
   parameter int WARM_N = `CWD_WARMUP_CLEAR
) (
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic reset_i,
   // Cycle events
   input  wire logic ign_start_i,
   input  wire logic warmup_done_i,
   input  wire logic ran_i,
   input  wire logic failed_i,
   input  wire logic other_fail_i,
   input  wire logic clear_i,
   // Status
   output logic      lamp_o,
   output logic      history_o
);
   // ***************************************
   // State
   // ***************************************
   typedef struct packed {
      logic       cyc_ran;
      logic       cyc_fail;
      logic       prev_fail;
      logic       lamp;
      logic       hist;
      logic       warm_fail;
      logic [4:0] warm_cnt;
   } cwd_ct_t;
   cwd_ct_t st_r, st_nxt;

   // Cycle closing decisions
   always_comb begin
      st_nxt = st_r;
      if (ran_i) st_nxt.cyc_ran = 1'b1;
      if (failed_i) begin
         st_nxt.cyc_fail  = 1'b1;
         st_nxt.hist      = 1'b1;
         st_nxt.warm_fail = 1'b1;
      end
      if (other_fail_i) st_nxt.warm_fail = 1'b1;
      // Failing cycle: lamp on the second in a row
      if (failed_i && st_r.prev_fail) st_nxt.lamp = 1'b1;
      if (ign_start_i) begin
         // A result in the start cycle belongs to the new cycle
         st_nxt.cyc_ran  = ran_i;
         st_nxt.cyc_fail = failed_i;
         if (st_r.cyc_ran) begin
            st_nxt.prev_fail = st_r.cyc_fail;
            if (!st_r.cyc_fail) st_nxt.lamp = 1'b0;
         end
      end
      // Warm-up aging of the history code
      if (warmup_done_i) begin
         st_nxt.warm_fail = 1'b0;
         if (st_r.warm_fail || failed_i || other_fail_i) begin
            st_nxt.warm_cnt = 5'h00;
         end else if (st_r.warm_cnt == 5'(WARM_N - 1)) begin
            st_nxt.warm_cnt = 5'h00;
            st_nxt.hist     = 1'b0;
         end else begin
            st_nxt.warm_cnt = st_r.warm_cnt + 5'h01;
         end
      end
      // Service tool clear
      if (clear_i) begin
         st_nxt = '0;
      end
   end

   // State register
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lamp_o    = st_r.lamp;
   assign history_o = st_r.hist;
endmodule // cwd_cycle_tracker
`default_nettype wire

//--- src/cwd_pkg.sv
// Types for the crank wheel decoder and fault monitor
package cwd_pkg;
   // Synchronisation state of the wheel decoder
   typedef enum logic [1:0] {
      CWD_SYNC_LOST,
      CWD_SYNC_SEEK,
      CWD_SYNC_LOCKED
   } cwd_sync_t;
endpackage

//--- src/cwd_tooth_timer.sv
// Measures period between crank pulse edges
`timescale 1ns/100ps
`default_nettype none
`include "cwd_cfg.svh"
module cwd_tooth_timer #(
   parameter int PER_W = `CWD_PER_W
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             reset_i,
   // Pulse input
   input  wire logic             pulse_i,
   // Results
   output logic                  edge_o,
   output logic [PER_W-1:0]      period_o,
   output logic [PER_W-1:0]      running_o
);
   // ***************************************
   // State
   // ***************************************
   typedef struct packed {
      logic             prev;
      logic             edge_seen;
      logic [PER_W-1:0] cnt;
      logic [PER_W-1:0] per;
   } cwd_tt_t;
   cwd_tt_t st_r, st_nxt;

   // Rising edge detection and period count
   always_comb begin
      st_nxt           = st_r;
      st_nxt.prev      = pulse_i;
      st_nxt.edge_seen = pulse_i & ~st_r.prev;
      if (pulse_i & ~st_r.prev) begin
         st_nxt.per = st_r.cnt;
         st_nxt.cnt = {{(PER_W-1){1'b0}}, 1'b1};
      end else if (~&st_r.cnt) begin
         st_nxt.cnt = st_r.cnt + {{(PER_W-1){1'b0}}, 1'b1};
      end
   end

   // State register
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign edge_o    = st_r.edge_seen;
   assign period_o  = st_r.per;
   assign running_o = st_r.cnt;
endmodule // cwd_tooth_timer
`default_nettype wire

//--- src/cwd_top.sv
// Crank wheel decoder and crank signal fault monitor
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "cwd_cfg.svh"
module cwd_top #(
   parameter int       PER_W      = `CWD_PER_W,
   parameter longint   TIMEOUT_CYC = `CWD_TIMEOUT_CYC,
   parameter int       SNAP_W     = 16
) (
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              reset_i,
   // Crank sensor
   input  wire logic              crank_position_sensor_i,
   // Engine state and cycle events
   input  wire logic              engine_active_i,
   input  wire logic              ign_start_i,
   input  wire logic              warmup_done_i,
   input  wire logic              other_fail_i,
   input  wire logic              service_clear_i,
   input  wire logic [SNAP_W-1:0] conditions_i,
   // Event schedule
   input  wire logic [5:0]        spark_tooth_i,
   input  wire logic [5:0]        fuel_tooth_i,
   input  wire logic [5:0]        cam_tooth_i,
   // Register port
   input  wire logic [3:0]        addr_i,
   input  wire logic [31:0]       wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic [31:0]            rdata_o,
   // Outputs
   output logic                   spark_o,
   output logic                   fuel_o,
   output logic                   cam_ref_o,
   output logic                   synced_o,
   output logic [5:0]             tooth_o,
   output logic [PER_W-1:0]       period_o,
   output logic                   fault_indicator_lamp_o,
   output logic                   code_current_o,
   output logic                   code_history_o,
   output logic                   irq_o
);
   // ***************************************
   // Register map
   // ***************************************
   localparam logic [3:0] A_STATUS = 4'h0;
   localparam logic [3:0] A_IRQ    = 4'h4;
   localparam logic [3:0] A_MASK   = 4'h8;
   localparam logic [3:0] A_SNAP   = 4'hC;
   localparam logic [3:0] A_CODE   = 4'h1;

   // ***************************************
   // Submodules
   // ***************************************
   logic             pedge;
   logic [PER_W-1:0] per, run;
   logic             lamp, hist;

   // Tooth period measurement
   cwd_tooth_timer #(.PER_W(PER_W)) u_timer (
      .clock_i  (clock_i),
      .reset_i  (reset_i),
      .pulse_i  (crank_position_sensor_i),
      .edge_o   (pedge),
      .period_o (per),
      .running_o(run)
   );

   // ***************************************
   // State
   // ***************************************
   typedef struct packed {
      cwd_pkg::cwd_sync_t sync;
      logic [5:0]         tooth;
      logic [PER_W-1:0]   last_per;
      logic [5:0]         since_gap;
      logic               spark;
      logic               fuel;
      logic               camref;
      logic [PER_W-1:0]   timeout;
      logic               cur;
      logic               fail_p;
      logic               pass_p;
      logic [SNAP_W-1:0]  snap;
      logic [2:0]         irq_st;
      logic [2:0]         mask;
      logic [31:0]        rdata;
   } cwd_st_t;
   cwd_st_t st_r, st_nxt;

   // Gap test: new period above 1.5 times previous
   function automatic logic is_gap(input logic [PER_W-1:0] np, input logic [PER_W-1:0] op);
      is_gap = ({1'b0, np} > ({1'b0, op} + {2'b00, op[PER_W-1:1]})) && (op != '0);
   endfunction

   // Decoder, scheduler, fault check, registers
   always_comb begin
      st_nxt        = st_r;
      st_nxt.spark  = 1'b0;
      st_nxt.fuel   = 1'b0;
      st_nxt.camref = 1'b0;
      st_nxt.fail_p = 1'b0;
      st_nxt.pass_p = 1'b0;
      st_nxt.rdata  = 32'h0000_0000;
      // Tooth handling on each pulse edge
      if (pedge) begin
         st_nxt.last_per = per;
         if (is_gap(per, st_r.last_per)) begin
            // Missing pair spans two extra positions
            if (st_r.sync == cwd_pkg::CWD_SYNC_LOCKED &&
                st_r.since_gap != 6'(`CWD_PULSES_PER_REV - 1)) begin
               st_nxt.sync = cwd_pkg::CWD_SYNC_SEEK;
            end else begin
               st_nxt.sync = cwd_pkg::CWD_SYNC_LOCKED;
            end
            st_nxt.tooth     = 6'h00;
            st_nxt.since_gap = 6'h00;
         end else begin
            st_nxt.since_gap = st_r.since_gap + 6'h01;
            st_nxt.tooth     = (st_r.tooth >= 6'(`CWD_WHEEL_POS - `CWD_WHEEL_MISSING - 1)) ?
                               6'h00 : st_r.tooth + 6'h01;
            if (st_r.sync == cwd_pkg::CWD_SYNC_LOST) st_nxt.sync = cwd_pkg::CWD_SYNC_SEEK;
            if (st_r.sync == cwd_pkg::CWD_SYNC_LOCKED &&
                st_r.since_gap >= 6'(`CWD_PULSES_PER_REV - 1)) begin
               st_nxt.sync = cwd_pkg::CWD_SYNC_SEEK;
            end
         end
         if (st_nxt.sync == cwd_pkg::CWD_SYNC_LOCKED) begin
            st_nxt.spark  = (st_nxt.tooth == spark_tooth_i);
            st_nxt.fuel   = (st_nxt.tooth == fuel_tooth_i);
            st_nxt.camref = (st_nxt.tooth == cam_tooth_i);
         end
      end
      // Loss of signal check while cranking or running
      if (!engine_active_i) begin
         // Engine stopped: check does not run
         st_nxt.timeout = '0;
      end else if (pedge) begin
         // Pulse seen: check passes, window restarts
         st_nxt.timeout = '0;
         st_nxt.pass_p  = 1'b1;
         st_nxt.cur     = 1'b0;
      end else if (st_r.timeout == PER_W'(TIMEOUT_CYC - 1)) begin
         // Full window of silence: fault, snapshot, angle lost
         st_nxt.timeout = '0;
         st_nxt.fail_p  = 1'b1;
         st_nxt.cur     = 1'b1;
         st_nxt.sync    = cwd_pkg::CWD_SYNC_LOST;
         st_nxt.snap    = conditions_i;
      end else begin
         // Still waiting for the next pulse
         st_nxt.timeout = st_r.timeout + {{(PER_W-1){1'b0}}, 1'b1};
      end
      // Register writes: clear-on-one status, mask
      if (wr_i && addr_i == A_IRQ)  st_nxt.irq_st = st_r.irq_st & ~wdata_i[2:0];
      if (wr_i && addr_i == A_MASK) st_nxt.mask   = wdata_i[2:0];
      // Sticky events win over a clear
      st_nxt.irq_st = st_nxt.irq_st | {pedge && is_gap(per, st_r.last_per), st_nxt.pass_p, st_nxt.fail_p};
      if (service_clear_i || (wr_i && addr_i == A_STATUS && wdata_i[0])) begin
         st_nxt.cur  = 1'b0;
         st_nxt.snap = '0;
      end
      // Register reads
      if (rd_i) begin
         case (addr_i)
            A_STATUS: st_nxt.rdata = {24'h0, hist, lamp, st_r.cur, st_r.sync, st_r.tooth[2:0]};
            A_IRQ:    st_nxt.rdata = {29'h0, st_r.irq_st};
            A_MASK:   st_nxt.rdata = {29'h0, st_r.mask};
            A_SNAP:   st_nxt.rdata = 32'(st_r.snap);
            A_CODE:   st_nxt.rdata = {17'h0, `CWD_FAULT_FMI, `CWD_FAULT_SPN};
            default:  st_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   // Lamp and history across ignition and warm-up cycles
   cwd_cycle_tracker u_cycles (
      .clock_i      (clock_i),
      .reset_i      (reset_i),
      .ign_start_i  (ign_start_i),
      .warmup_done_i(warmup_done_i),
      .ran_i        (st_r.pass_p | st_r.fail_p),
      .failed_i     (st_r.fail_p),
      .other_fail_i (other_fail_i),
      .clear_i      (service_clear_i | (wr_i && addr_i == A_STATUS && wdata_i[0])),
      .lamp_o       (lamp),
      .history_o    (hist)
   );

   // State register
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Output flops
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(st_nxt.irq_st & st_nxt.mask);
      end
   end
   assign rdata_o                = st_r.rdata;
   assign spark_o                = st_r.spark;
   assign fuel_o                 = st_r.fuel;
   assign cam_ref_o              = st_r.camref;
   assign synced_o               = (st_r.sync == cwd_pkg::CWD_SYNC_LOCKED);
   assign tooth_o                = st_r.tooth;
   assign period_o               = st_r.last_per;
   assign fault_indicator_lamp_o = lamp;
   assign code_current_o         = st_r.cur;
   assign code_history_o         = hist;

   // ***************************************
   // Checks
   // ***************************************
   // A fault raises the current code unless a service clear or status clear write comes in the same cycle
   a_timeout_sets_code: assert property (@(posedge clock_i) disable iff (reset_i)
      st_r.fail_p |-> st_r.cur) else $error("timeout without current code");
   // No fault while the engine is stopped
   a_idle_no_check: assert property (@(posedge clock_i) disable iff (reset_i)
      !engine_active_i |=> !st_r.fail_p) else $error("check ran while engine stopped");
   // A pulse while active clears the current code
   a_pass_clears: assert property (@(posedge clock_i) disable iff (reset_i)
      (engine_active_i && pedge && !service_clear_i) |=> !st_r.cur) else $error("pass left code");
   // Service clear puts the lamp out
   a_service_clear: assert property (@(posedge clock_i) disable iff (reset_i)
      service_clear_i |=> ##1 !lamp) else $error("lamp survived clear");
   // Snapshot holds the conditions of the failing cycle
   a_snap_taken: assert property (@(posedge clock_i) disable iff (reset_i)
      (st_nxt.fail_p && !service_clear_i) |=> st_r.snap == $past(conditions_i)) else $error("no snapshot");
   // Gap restarts the tooth count
   a_gap_zero: assert property (@(posedge clock_i) disable iff (reset_i)
      (pedge && is_gap(per, st_r.last_per)) |=> st_r.tooth == 6'h00) else $error("gap not at zero");
   // Tooth index stays on the wheel
   a_tooth_range: assert property (@(posedge clock_i) disable iff (reset_i)
      st_r.tooth < 6'(`CWD_PULSES_PER_REV)) else $error("tooth past 57");
   // Spark only while locked
   a_spark_locked: assert property (@(posedge clock_i) disable iff (reset_i)
      spark_o |-> synced_o) else $error("spark without sync");
   // Fuel only while locked
   a_fuel_locked: assert property (@(posedge clock_i) disable iff (reset_i)
      fuel_o |-> synced_o) else $error("fuel without sync");
   // Cam reference only while locked
   a_cam_locked: assert property (@(posedge clock_i) disable iff (reset_i)
      cam_ref_o |-> synced_o) else $error("cam reference without sync");
   // Spark on its scheduled tooth
   a_spark_tooth: assert property (@(posedge clock_i) disable iff (reset_i)
      spark_o |-> tooth_o == $past(spark_tooth_i)) else $error("spark on wrong tooth");
   // Fuel on its scheduled tooth
   a_fuel_tooth: assert property (@(posedge clock_i) disable iff (reset_i)
      fuel_o |-> tooth_o == $past(fuel_tooth_i)) else $error("fuel on wrong tooth");
   // Cam reference on its scheduled tooth
   a_cam_tooth: assert property (@(posedge clock_i) disable iff (reset_i)
      cam_ref_o |-> tooth_o == $past(cam_tooth_i)) else $error("cam reference on wrong tooth");
   // Every pulse period is reported
   a_period_taken: assert property (@(posedge clock_i) disable iff (reset_i)
      pedge |=> period_o == $past(per)) else $error("period not updated");
   // Fault only after an active cycle
   a_fault_active: assert property (@(posedge clock_i) disable iff (reset_i)
      st_r.fail_p |-> $past(engine_active_i)) else $error("fault while engine stopped");
   // Gap gives lock when not locked
   a_lock_on_gap: assert property (@(posedge clock_i) disable iff (reset_i)
      (pedge && is_gap(per, st_r.last_per) && !synced_o) |=> synced_o) else $error("gap did not lock");
   // Wrong tooth count between gaps drops lock
   a_count_lock: assert property (@(posedge clock_i) disable iff (reset_i)
      (pedge && is_gap(per, st_r.last_per) && synced_o &&
       st_r.since_gap != 6'(`CWD_PULSES_PER_REV - 1)) |=> !synced_o) else $error("lock kept on bad count");
   // Code register reads the fixed fault code
   a_code_value: assert property (@(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == A_CODE) |=> rdata_o == {17'h0, `CWD_FAULT_FMI, `CWD_FAULT_SPN}) else $error("wrong code");
   // Read data only in the cycle after a read
   a_rdata_idle: assert property (@(posedge clock_i) disable iff (reset_i)
      !rd_i |=> rdata_o == 32'h0000_0000) else $error("read data without read");
   // Service clear drops the current code
   a_clear_code: assert property (@(posedge clock_i) disable iff (reset_i)
      service_clear_i |=> !code_current_o) else $error("code survived clear");
   // Interrupt follows the unmasked sticky bits
   a_irq_level: assert property (@(posedge clock_i) disable iff (reset_i)
      irq_o == |(st_r.irq_st & st_r.mask)) else $error("interrupt level wrong");
   // Fault drops angle lock
   a_fault_unlocks: assert property (@(posedge clock_i) disable iff (reset_i)
      st_r.fail_p |-> !synced_o) else $error("lock kept after fault");
endmodule // cwd_top
`default_nettype wire

//--- tb/cwd_crank_model.sv
// Crank sensor model: 60-minus-2 wheel pulse train
`timescale 1ns/100ps
`default_nettype none
module cwd_crank_model #(
   parameter int P = 40
) (
   // Clock
   input  wire logic clock_i,
   // Wheel turning
   input  wire logic run_i,
   // Sensor output
   output var logic  pulse_o
);
   // ****************************************
   // Tooth generator
   // ****************************************
   int cnt = 0;     // Clocks into current tooth window
   int tooth = 0;   // Tooth index, 0 after gap
   initial pulse_o = 1'b0;
   // Last tooth window spans the two missing teeth
   always @(posedge clock_i) begin
      if (!run_i) begin
         // Stopped wheel gives no edges
         cnt <= 0;
         pulse_o <= 1'b0;
      end else begin
         if (cnt == ((tooth == 57) ? 3 * P : P) - 1) begin
            cnt <= 0;
            tooth <= (tooth == 57) ? 0 : tooth + 1;
         end else begin
            cnt <= cnt + 1;
         end
         pulse_o <= (cnt < P / 2);
      end
   end
endmodule // cwd_crank_model
`default_nettype wire

//--- tb/cwd_top_test.sv
// Self-checking bench for the crank decoder and fault monitor
`timescale 1ns/100ps
`default_nettype none
module cwd_top_test;
   // ****************************************
   // Signals
   // ****************************************
   localparam int P   = 40;            // Tooth spacing in clocks
   localparam int REV = 60 * P;        // Clocks per revolution
   logic        clock_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        run     = 1'b0;        // Wheel turning
   logic        eng     = 1'b0;        // Cranking or running
   logic        ign     = 1'b0;
   logic        warm    = 1'b0;
   logic        ofail   = 1'b0;
   logic        sclr    = 1'b0;
   logic [15:0] cond    = 16'h0000;
   logic [3:0]  addr    = 4'h0;
   logic [31:0] wdata   = 32'h0000_0000;
   logic        wr      = 1'b0;
   logic        rd      = 1'b0;
   logic [31:0] d;                     // Read result
   logic        crank, spark, fuel, cam, synced, lamp, cur, hist, irq;
   logic [5:0]  tooth, sp_tooth;
   logic [31:0] rdata, period;
   int          mismatches = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          n_sp = 0, n_fu = 0, n_cm = 0;
   // ****************************************
   // Instances
   // ****************************************
   cwd_crank_model #(.P(P)) wheel (.clock_i(clock_i), .run_i(run), .pulse_o(crank));
   cwd_top #(.TIMEOUT_CYC(1000)) dut (
      .clock_i(clock_i), .reset_i(reset_i), .crank_position_sensor_i(crank),
      .engine_active_i(eng), .ign_start_i(ign), .warmup_done_i(warm),
      .other_fail_i(ofail), .service_clear_i(sclr), .conditions_i(cond),
      .spark_tooth_i(6'h05), .fuel_tooth_i(6'h0A), .cam_tooth_i(6'h00),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .spark_o(spark), .fuel_o(fuel), .cam_ref_o(cam), .synced_o(synced),
      .tooth_o(tooth), .period_o(period), .fault_indicator_lamp_o(lamp),
      .code_current_o(cur), .code_history_o(hist), .irq_o(irq));
   // ****************************************
   // Clock, event counters, timeout
   // ****************************************
   initial forever #2.5 clock_i = ~clock_i;
   // Counted on the falling edge, clear of the launching edge
   always @(negedge clock_i) begin
      cyc <= cyc + 1;
      if (spark === 1'b1) begin
         n_sp <= n_sp + 1;
         sp_tooth <= tooth;
      end
      if (fuel === 1'b1) n_fu <= n_fu + 1;
      if (cam === 1'b1) n_cm <= n_cm + 1;
      if (cyc == 40000) begin
         mismatches++;
         give_verdict();
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // One-cycle strobe: 0 ignition, 1 warm-up, 2 other fail, 3 clear
   task automatic strobe(input int w);
      @(posedge clock_i);
      ign <= (w == 0);
      warm <= (w == 1);
      ofail <= (w == 2);
      sclr <= (w == 3);
      @(posedge clock_i);
      {ign, warm, ofail, sclr} <= 4'h0;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clock_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clock_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_cur(input logic v);
      for (int i = 0; i < 3000 && cur !== v; i++) tick(1);
      tick(1);
   endtask
   task automatic give_verdict();
      if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      tick(1);
      chk("outputs", 32'h0, {cur, hist, lamp, synced, irq, spark});
      reg_rd(4'h0, d); chk("status", 32'h0, d);
      reg_rd(4'h7, d); chk("unmapped", 32'h0, d);
      // Engine stopped: no fault however long the silence
      tick(1500); chk("idle current", 32'h0, cur);
      // First failing ignition cycle
      strobe(0);
      eng <= 1'b1;
      cond <= 16'hA5C3;
      wait_cur(1'b1); chk("current", 32'h1, cur);
      chk("lamp first", 32'h0, lamp);
      chk("history", 32'h1, hist);
      @(posedge clock_i);
      cond <= 16'h1234;
      reg_rd(4'hC, d); chk("snapshot", 32'h0000_A5C3, d);
      reg_rd(4'h1, d); chk("code", 32'h0000_0A7C, d);
      reg_rd(4'h4, d); chk("fault flag", 32'h1, {31'h0, d[0]});
      reg_wr(4'h8, 32'h1); tick(2); chk("irq on", 32'h1, irq);
      reg_wr(4'h8, 32'h0); tick(2); chk("irq masked", 32'h0, irq);
      reg_wr(4'h4, 32'h7); reg_wr(4'h8, 32'h1); tick(2); chk("irq clear", 32'h0, irq);
      reg_rd(4'h8, d); chk("mask", 32'h1, d);
      // Second failing ignition cycle lights the lamp
      strobe(0); tick(1100); chk("lamp second", 32'h1, lamp);
      chk("irq again", 32'h1, irq);
      // Wheel turns: lock, speed, events
      @(posedge clock_i);
      run <= 1'b1;
      tick(2 * REV + 200);
      chk("synced", 32'h1, synced);
      chk("current pass", 32'h0, cur);
      chk("period", P, period);
      reg_rd(4'h0, d); chk("sync field", 32'h2, {30'h0, d[4:3]});
      n_sp = 0;
      n_fu = 0;
      n_cm = 0;
      tick(REV);
      chk("spark count", 32'h1, n_sp);
      chk("spark tooth", 32'h5, sp_tooth);
      chk("fuel count", 32'h1, n_fu);
      chk("cam count", 32'h1, n_cm);
      chk("still synced", 32'h1, synced);
      // Closing a failed cycle keeps lamp, a clean one clears it
      strobe(0); tick(4); chk("lamp kept", 32'h1, lamp);
      tick(REV);
      strobe(0); tick(4); chk("lamp off", 32'h0, lamp);
      // History needs 25 clean warm-ups in a row; the cycle with the other failure is not clean
      repeat (10) strobe(1);
      strobe(2);
      repeat (25) strobe(1);
      tick(4); chk("history 24", 32'h1, hist);
      strobe(1); tick(4); chk("history 25", 32'h0, hist);
      // Service clear by port and by register write
      @(posedge clock_i);
      run <= 1'b0;
      wait_cur(1'b1); chk("refail", 32'h3, {cur, hist});
      strobe(3); tick(4); chk("port clear", 32'h0, {cur, hist, lamp});
      wait_cur(1'b1);
      reg_wr(4'h0, 32'h1); tick(4); chk("reg clear", 32'h0, {cur, hist, lamp});
      give_verdict();
   end
endmodule // cwd_top_test
`default_nettype wire
